// ---- mao_bus_ctl.sv ----
// Bus controller: operand splitting, single reads, line and prefetch reads
`timescale 1ns/100ps
`include "mao_defs.svh"
module mao_bus_ctl
  import mao_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic [31:0] reqAddr,
  input wire logic [1:0] reqWidth,
  input wire logic reqInstr,
  input wire logic reqCachable,
  input wire logic [1:0] reqUserBits,
  input wire logic [1:0] reqClass,
  input wire logic [2:0] reqModifier,
  output logic rspValid,
  output logic rspLast,
  output logic [31:0] rspData,
  output logic rspFillInhibit,
  output logic addrError,
  output logic [31:0] addrOut,
  output logic [1:0] transferWidthCode,
  output logic readWrite,
  output logic [1:0] userPageAttr,
  output logic [1:0] accessClass,
  output logic [2:0] accessModifier,
  output logic nocacheOut_b,
  output logic cycleBeginStrobe_b,
  output logic cycleActive_b,
  input wire logic transferAck_b,
  input wire logic burstRefuse_b,
  input wire logic fillInhibitIn_b,
  input wire logic [31:0] dataIn
);
  mao_sync_if syn ();
  mao_state_t state;
  mao_state_t next_state;
  mao_mode_t mode;
  logic [31:0] curAddr;
  logic [2:0] rem;
  logic [2:0] beats;
  logic burst;
  logic [31:0] acc;
  logic cycle_active;
  logic nocache;
  logic [1:0] pieceWidth;
  logic [2:0] pieceBytes;
  logic [2:0] remAfter;
  logic take;
  logic instrOdd;
  logic ackNow;
  logic firstRefuse;
  logic finished;
  logic restart;
  logic ts;
  logic [31:0] merged;
  logic [31:0] lineNext;

  // Bytes of an operand of the given width code
  function automatic logic [2:0] bytesOf(input logic [1:0] w);
    bytesOf = (w == `MAO_SZ_BYTE) ? 3'h1 : ((w == `MAO_SZ_WORD) ? 3'h2 : 3'h4);
  endfunction

  // Pull n bytes at lane offset o; offset 0 sits on the top lane
  function automatic logic [31:0] laneVal(input logic [31:0] d, input logic [1:0] o,
                                          input logic [2:0] n);
    logic [2:0] lo;
    logic [31:0] sh;
    lo = 3'h4 - {1'b0, o} - n;
    sh = d >> {lo, 3'h0};
    laneVal = (n == 3'h1) ? (sh & 32'h000000ff) : ((n == 3'h2) ? (sh & 32'h0000ffff) : sh);
  endfunction

  mao_sync u_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .transferAck_b(transferAck_b),
    .burstRefuse_b(burstRefuse_b),
    .fillInhibitIn_b(fillInhibitIn_b),
    .dataIn(dataIn),
    .syn(syn)
  );

  mao_split u_split (
    .offset(curAddr[1:0]),
    .remain(rem),
    .width(pieceWidth),
    .bytes(pieceBytes)
  );

  // Request decode and cycle-end conditions
  assign reqReady = (state == ST_IDLE);
  assign take = reqValid && reqReady;
  assign instrOdd = reqInstr && reqAddr[0];
  assign ts = (state == ST_START);
  assign ackNow = (state == ST_WAIT) && syn.ack;
  assign firstRefuse = (mode == MD_LINE) && burst && (beats == `MAO_LINE_BEATS)
                       && syn.refuse;
  assign remAfter = rem - pieceBytes;
  assign finished = ackNow && ((mode == MD_SPLIT) ? (remAfter == 3'h0) : (beats == 3'h1));
  assign restart = ackNow && !finished && ((mode != MD_LINE) || !burst || firstRefuse);
  assign merged = (acc << {pieceBytes, 3'h0}) | laneVal(syn.data, curAddr[1:0], pieceBytes);
  // Refused line walks A3:A2 with wrap; BYTE_LANE_OFFSET stay as first issued
  assign lineNext = {curAddr[31:4], curAddr[3:2] + 2'h1, curAddr[1:0]};

  // Start strobe lasts one clock since START always moves to WAIT
  assign next_state = (take && !instrOdd) ? ST_START :
                      ts ? ST_WAIT :
                      finished ? ST_IDLE :
                      restart ? ST_START : state;

  // Bus outputs; width code follows the piece for splits, line while bursting, long otherwise
  assign transferWidthCode = (mode == MD_SPLIT) ? pieceWidth :
                             ((mode == MD_LINE) && burst) ? `MAO_SZ_LINE : `MAO_SZ_LONG;
  assign addrOut = curAddr;
  assign readWrite = 1'b1;
  assign nocacheOut_b = !nocache;
  assign cycleBeginStrobe_b = !ts;
  assign cycleActive_b = !cycle_active;

  // State and cycle-active; active rises with the strobe, holds across restarts
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      state <= ST_IDLE;
      cycle_active <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cycle_active <= (next_state != ST_IDLE);
    end
  end

  // Attributes latched once per request, stable over all its cycles
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      userPageAttr <= 2'h0;
      accessClass <= 2'h0;
      accessModifier <= 3'h0;
      nocache <= 1'b0;
    end
    else if (take && !instrOdd)
    begin
      userPageAttr <= reqUserBits;
      accessClass <= reqClass;
      accessModifier <= reqModifier;
      nocache <= reqInstr || !reqCachable;
    end
  end

  // Request setup: prefetch, line fill for cachable, split otherwise
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      mode <= MD_SPLIT;
      curAddr <= 32'h0;
      rem <= 3'h0;
      beats <= 3'h0;
      burst <= 1'b0;
    end
    else if (take && !instrOdd)
    begin
      rem <= bytesOf(reqWidth);
      if (reqInstr)
      begin
        mode <= MD_INSTR;
        curAddr <= reqAddr & `MAO_HALF_MASK;
        beats <= reqAddr[2] ? 3'h2 : 3'h1;
        burst <= 1'b0;
      end
      else if (reqCachable)
      begin
        mode <= MD_LINE;
        curAddr <= reqAddr;
        beats <= `MAO_LINE_BEATS;
        burst <= 1'b1;
      end
      else
      begin
        mode <= MD_SPLIT;
        curAddr <= reqAddr;
        beats <= 3'h0;
        burst <= 1'b0;
      end
    end
    else if (ackNow)
    begin
      if (mode == MD_SPLIT)
      begin
        rem <= remAfter;
        curAddr <= curAddr + {29'h0, pieceBytes};
      end
      else if (firstRefuse)
      begin
        burst <= 1'b0;
        beats <= `MAO_REFUSED_BEATS;
        curAddr <= lineNext;
      end
      else
      begin
        beats <= beats - 3'h1;
        if (mode == MD_INSTR)
          curAddr <= curAddr + `MAO_LONG_STEP;
        else if (!burst)
          curAddr <= lineNext;
      end
    end
  end

  // Data path: operand bytes gathered in order, long words passed per beat
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      acc <= 32'h0;
      rspValid <= 1'b0;
      rspLast <= 1'b0;
      rspData <= 32'h0;
      rspFillInhibit <= 1'b0;
      addrError <= 1'b0;
    end
    else
    begin
      addrError <= take && instrOdd;
      rspValid <= ackNow && ((mode != MD_SPLIT) || finished);
      rspLast <= finished;
      if (take)
        acc <= 32'h0;
      else if (ackNow && (mode == MD_SPLIT))
        acc <= merged;
      if (ackNow)
        rspData <= (mode == MD_SPLIT) ? merged : syn.data;
      // Only the first line beat carries fill-inhibit; single reads never do
      if (ackNow && (mode == MD_LINE) && burst && (beats == `MAO_LINE_BEATS))
        rspFillInhibit <= syn.inhibit;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence longOff1Ack;
    ackNow && (mode == MD_SPLIT) && (rem == 3'h4) && (curAddr[1:0] == 2'h1);
  endsequence
  sequence wordAt2Start;
    ts && (transferWidthCode == `MAO_SZ_WORD) && (addrOut[1:0] == 2'h2);
  endsequence
  sequence wordOff2Ack;
    ackNow && (mode == MD_SPLIT) && (rem == 3'h3) && (curAddr[1:0] == 2'h2);
  endsequence
  sequence byteNextLong;
    ts && (transferWidthCode == `MAO_SZ_BYTE) && (addrOut[1:0] == 2'h0);
  endsequence

  strobe_one_clk_a: assert property ($rose(ts) |=> !ts && (state == ST_WAIT))
    else $error("strobe longer than one clock");
  strobe_with_active_a: assert property (ts |-> cycle_active)
    else $error("strobe without cycle-active");
  aligned_piece_a: assert property (ts && (mode == MD_SPLIT)
    |-> (transferWidthCode == `MAO_SZ_BYTE) || (addrOut[0] == 1'b0
    && (transferWidthCode == `MAO_SZ_WORD || addrOut[1:0] == 2'h0)))
    else $error("misaligned bus piece");
  long_off1_order_a: assert property (longOff1Ack |=> wordAt2Start)
    else $error("second piece not word at offset 2");
  long_off1_tail_a: assert property (wordOff2Ack |=> byteNextLong)
    else $error("third piece not byte at offset 0");
  wait_holds_a: assert property ((state == ST_WAIT) && !syn.ack
    |=> (state == ST_WAIT) && $stable(addrOut) && !rspValid)
    else $error("cycle ended without ack");
  refuse_singles_a: assert property (ackNow && firstRefuse
    |=> ts && (transferWidthCode == `MAO_SZ_LONG) && (beats == 3'h3))
    else $error("refused line not continued by long reads");
  prefetch_align_a: assert property (ts && (mode == MD_INSTR)
    |-> (addrOut[1:0] == 2'h0) && (transferWidthCode == `MAO_SZ_LONG))
    else $error("prefetch not a long word on long boundary");
  odd_prefetch_a: assert property (take && instrOdd |=> addrError && (state == ST_IDLE))
    else $error("odd prefetch not refused");
  active_drop_a: assert property (finished |=> !cycle_active && !ts && cycleActive_b)
    else $error("cycle-active not dropped after last ack");
  active_keep_a: assert property (restart |=> cycle_active && ts)
    else $error("cycle-active dropped between chained cycles");
  single_attr_a: assert property (ts && (mode == MD_SPLIT) |-> !nocacheOut_b && readWrite)
    else $error("single read attributes wrong");
  inhibit_ignored_a: assert property (ackNow && (mode != MD_LINE)
    |=> $stable(rspFillInhibit))
    else $error("fill-inhibit taken on single read");
endmodule

// ---- mao_defs.svh ----
// Constants for the misaligned operand splitter and single read controller
`ifndef MAO_DEFS_SVH
`define MAO_DEFS_SVH
`define MAO_SZ_LONG 2'h0
`define MAO_SZ_BYTE 2'h1
`define MAO_SZ_WORD 2'h2
`define MAO_SZ_LINE 2'h3
`define MAO_LINE_BEATS 3'h4
`define MAO_REFUSED_BEATS 3'h3
`define MAO_HALF_MASK 32'hfffffff8
`define MAO_LONG_STEP 32'h00000004
`define MAO_CLK_NS 25
`endif

// ---- mao_pkg.sv ----
// Types shared by the bus controller modules
package mao_pkg;
  typedef enum {ST_IDLE, ST_START, ST_WAIT} mao_state_t;
  typedef enum {MD_SPLIT, MD_LINE, MD_INSTR} mao_mode_t;
endpackage

// ---- mao_sync_if.sv ----
// Synchronised bus inputs passed from the input stage to the controller
`timescale 1ns/100ps
interface mao_sync_if;
  logic ack;
  logic refuse;
  logic inhibit;
  logic [31:0] data;
  modport src (output ack, output refuse, output inhibit, output data);
  modport dst (input ack, input refuse, input inhibit, input data);
endinterface

// ---- mao_sync.sv ----
// Two flip-flop input stage for slave-driven bus pins
`timescale 1ns/100ps
module mao_sync
  import mao_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic transferAck_b,
  input wire logic burstRefuse_b,
  input wire logic fillInhibitIn_b,
  input wire logic [31:0] dataIn,
  mao_sync_if.src syn
);
  logic [34:0] stage1;
  logic [34:0] stage2;

  // Data is delayed with the strobes so the latched word matches its ack
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      stage1 <= 35'h0;
      stage2 <= 35'h0;
    end
    else
    begin
      stage1 <= {~transferAck_b, ~burstRefuse_b, ~fillInhibitIn_b, dataIn};
      stage2 <= stage1;
    end
  end

  // Active-high views of the sampled pins
  assign syn.ack = stage2[34];
  assign syn.refuse = stage2[33];
  assign syn.inhibit = stage2[32];
  assign syn.data = stage2[31:0];
endmodule

// ---- mao_split.sv ----
// Picks the next aligned piece of a noncachable operand access
`timescale 1ns/100ps
`include "mao_defs.svh"
module mao_split
  import mao_pkg::*;
(
  input wire logic [1:0] offset,
  input wire logic [2:0] remain,
  output logic [1:0] width,
  output logic [2:0] bytes
);
  logic oddAddr;
  logic atHalf;

  // Odd address or single byte left gives a byte; offset 2 caps at a word
  assign oddAddr = offset[0] || (remain == 3'h1);
  assign atHalf = offset[1] || (remain < 3'h4);
  assign width = oddAddr ? `MAO_SZ_BYTE : (atHalf ? `MAO_SZ_WORD : `MAO_SZ_LONG);
  assign bytes = oddAddr ? 3'h1 : (atHalf ? 3'h2 : 3'h4);
endmodule

// ---- mao_slave_model.sv ----
// Behavioural memory slave answering single, line and burst-refused reads
`timescale 1ns/100ps
`include "mao_defs.svh"
module mao_slave_model
  import mao_pkg::*;
(
  input wire logic clk_sys,
  input wire logic cycleBeginStrobe_b,
  input wire logic [31:0] addrOut,
  input wire logic [1:0] transferWidthCode,
  input wire logic [3:0] waitClocks,
  input wire logic refuseEn,
  input wire logic inhibitEn,
  output logic transferAck_b,
  output logic burstRefuse_b,
  output logic fillInhibitIn_b,
  output logic [31:0] dataIn
);
  logic [3:0] cnt;
  logic [2:0] beats;
  logic first;
  logic isLine;
  logic [31:0] cur;
  // Byte k of a long word holds its own address bits, so lanes are traceable
  function automatic logic [31:0] longAt(input logic [31:0] a);
    for (int k = 0; k < 4; k++)
      longAt[31 - 8 * k -: 8] = {a[7:2], k[1:0]} ^ 8'ha5;
  endfunction
  initial
  begin
    transferAck_b = 1'b1;
    burstRefuse_b = 1'b1;
    fillInhibitIn_b = 1'b1;
    dataIn = 32'h0;
    beats = 3'h0;
  end
  // Everything moves just after the rising edge; the data bus toggles when released
  always @(posedge clk_sys)
  begin
    transferAck_b <= 1'b1;
    burstRefuse_b <= 1'b1;
    fillInhibitIn_b <= 1'b1;
    dataIn <= ~dataIn;
    if (!cycleBeginStrobe_b)
    begin
      isLine <= (transferWidthCode == `MAO_SZ_LINE);
      beats <= (transferWidthCode == `MAO_SZ_LINE) ? 3'h4 : 3'h1;
      first <= 1'b1;
      cnt <= waitClocks;
      cur <= addrOut;
    end
    else if (beats != 3'h0)
    begin
      if (cnt != 4'h0)
        cnt <= cnt - 4'h1;
      else
      begin
        transferAck_b <= 1'b0;
        dataIn <= longAt(cur);
        burstRefuse_b <= !(first && refuseEn && isLine);
        fillInhibitIn_b <= !(first && inhibitEn);
        first <= 1'b0;
        cnt <= waitClocks;
        cur <= {cur[31:4], cur[3:2] + 2'h1, cur[1:0]};
        beats <= (first && refuseEn && isLine) ? 3'h0 : beats - 3'h1;
      end
    end
  end
endmodule

// ---- test_misaligned_split_and_single_read.sv ----
// Self-checking bench for the operand splitter and single read controller
`timescale 1ns/100ps
`include "mao_defs.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module test_misaligned_split_and_single_read;
  logic clk_sys, rst_b, reqValid, reqReady, reqInstr, reqCachable, rspValid, rspLast;
  logic [31:0] reqAddr, rspData, addrOut, dataIn, lastData;
  logic [1:0] reqWidth, reqUserBits, reqClass, transferWidthCode, userPageAttr, accessClass;
  logic [2:0] reqModifier, accessModifier;
  logic rspFillInhibit, addrError, readWrite, nocacheOut_b, cycleBeginStrobe_b, cycleActive_b;
  logic transferAck_b, burstRefuse_b, fillInhibitIn_b, refuseEn, inhibitEn, prevS, expNc, sawErr;
  logic [3:0] waitClocks;
  logic [1:0] sw[8];
  logic [31:0] sa[8];
  int failures = 0;
  int n_checks = 0;
  int nStrobe, beats;
  mao_bus_ctl dut (.clk_sys, .rst_b, .reqValid, .reqReady, .reqAddr, .reqWidth, .reqInstr,
    .reqCachable, .reqUserBits, .reqClass, .reqModifier, .rspValid, .rspLast, .rspData,
    .rspFillInhibit, .addrError, .addrOut, .transferWidthCode, .readWrite, .userPageAttr,
    .accessClass, .accessModifier, .nocacheOut_b, .cycleBeginStrobe_b, .cycleActive_b,
    .transferAck_b, .burstRefuse_b, .fillInhibitIn_b, .dataIn);
  mao_slave_model slave (.clk_sys, .cycleBeginStrobe_b, .addrOut, .transferWidthCode,
    .waitClocks, .refuseEn, .inhibitEn, .transferAck_b, .burstRefuse_b, .fillInhibitIn_b,
    .dataIn);
  // Expected memory byte, same pattern the slave serves
  function automatic logic [7:0] mb(input logic [31:0] a);
    mb = a[7:0] ^ 8'ha5;
  endfunction
  function automatic logic [31:0] op(input logic [31:0] a);
    op = {mb(a), mb(a + 1), mb(a + 2), mb(a + 3)};
  endfunction
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Log every bus cycle start and judge attributes at the strobe clock
  always @(posedge clk_sys)
  begin
    if (rst_b && !cycleBeginStrobe_b)
    begin
      if (nStrobe < 8)
      begin
        sw[nStrobe] = transferWidthCode;
        sa[nStrobe] = addrOut;
      end
      nStrobe++;
      `CHK("strobe width", 1'b1, prevS)
      `CHK("active", 1'b0, cycleActive_b)
      `CHK("attrs", 7'h4d, {userPageAttr, accessClass, accessModifier})
      `CHK("read", 1'b1, readWrite)
      `CHK("nocache", expNc, nocacheOut_b)
    end
    prevS <= cycleBeginStrobe_b;
  end
  // One request, then collect beats until the last one or an address error
  task automatic run(input logic [31:0] a, input logic [1:0] w, input logic ins, cach);
    int i;
    @(negedge clk_sys);
    reqAddr = a;
    reqWidth = w;
    reqInstr = ins;
    reqCachable = cach;
    reqValid = 1'b1;
    nStrobe = 0;
    beats = 0;
    sawErr = 1'b0;
    @(negedge clk_sys);
    reqValid = 1'b0;
    for (i = 0; i < 300; i++)
    begin
      if (rspValid === 1'b1)
      begin
        beats++;
        lastData = rspData;
      end
      if (addrError === 1'b1)
        sawErr = 1'b1;
      if (rspLast === 1'b1 || sawErr)
        break;
      @(negedge clk_sys);
    end
    repeat (3) @(negedge clk_sys);
    `CHK("idle active", 1'b1, cycleActive_b)
  endtask
  task automatic test_long;
    int n[4] = '{1, 3, 2, 3};
    for (int k = 0; k < 4; k++)
    begin
      run(32'h100 + k, `MAO_SZ_LONG, 1'b0, 1'b0);
      `CHK("long cycles", n[k], nStrobe)
      `CHK("long data", op(32'h100 + k), lastData)
      // Piece order is judged right after its run; later runs overwrite the log
      if (k == 1)
      begin
        `CHK("long1 widths", 6'h19, {sw[0], sw[1], sw[2]})
        `CHK("long1 addrs", {32'h101, 32'h102, 32'h104}, {sa[0], sa[1], sa[2]})
      end
      if (k == 3)
      begin
        `CHK("long3 widths", 6'h19, {sw[0], sw[1], sw[2]})
        `CHK("long3 addrs", {32'h103, 32'h104, 32'h106}, {sa[0], sa[1], sa[2]})
      end
    end
    $display("long split done");
  endtask
  task automatic test_word_byte;
    int n[4] = '{1, 2, 1, 2};
    for (int k = 0; k < 4; k++)
    begin
      run(32'h100 + k, `MAO_SZ_WORD, 1'b0, 1'b0);
      `CHK("word cycles", n[k], nStrobe)
      `CHK("word data", op(32'h100 + k) >> 16, lastData[15:0])
      run(32'h100 + k, `MAO_SZ_BYTE, 1'b0, 1'b0);
      `CHK("byte cycles", 1, nStrobe)
      `CHK("byte data", mb(32'h100 + k), lastData[7:0])
    end
    run(32'h103, `MAO_SZ_WORD, 1'b0, 1'b0);
    `CHK("word3 pieces", 4'h5, {sw[0], sw[1]})
    `CHK("word3 second", 32'h104, sa[1])
    $display("word and byte done");
  endtask
  task automatic test_waits;
    waitClocks = 4'h3;
    inhibitEn = 1'b1;
    run(32'h201, `MAO_SZ_LONG, 1'b0, 1'b0);
    `CHK("wait cycles", 3, nStrobe)
    `CHK("wait data", op(32'h201), lastData)
    // Slave raised fill-inhibit with every single ack; it must not reach the output
    `CHK("single inhibit", 1'b0, rspFillInhibit)
    waitClocks = 4'h0;
    inhibitEn = 1'b0;
    $display("wait states done");
  endtask
  task automatic test_prefetch;
    run(32'h301, `MAO_SZ_LONG, 1'b1, 1'b0);
    `CHK("odd fetch error", 1'b1, sawErr)
    `CHK("odd fetch cycles", 0, nStrobe)
    run(32'h30c, `MAO_SZ_LONG, 1'b1, 1'b0);
    `CHK("fetch beats", 2, beats)
    `CHK("fetch addrs", {32'h308, 32'h30c}, {sa[0], sa[1]})
    `CHK("fetch data", op(32'h30c), lastData)
    run(32'h300, `MAO_SZ_LONG, 1'b1, 1'b0);
    `CHK("fetch one", 1, beats)
    $display("prefetch done");
  endtask
  task automatic test_line;
    expNc = 1'b1;
    run(32'h404, `MAO_SZ_LONG, 1'b0, 1'b1);
    `CHK("line cycles", 1, nStrobe)
    `CHK("line width", `MAO_SZ_LINE, sw[0])
    `CHK("line beats", 4, beats)
    `CHK("line data", op(32'h400), lastData)
    refuseEn = 1'b1;
    inhibitEn = 1'b1;
    run(32'h406, `MAO_SZ_LONG, 1'b0, 1'b1);
    `CHK("refused cycles", 4, nStrobe)
    `CHK("refused widths", 6'h0, {sw[1], sw[2], sw[3]})
    `CHK("refused addrs", {32'h40a, 32'h40e, 32'h402}, {sa[1], sa[2], sa[3]})
    `CHK("refused data", op(32'h400), lastData)
    `CHK("fill inhibit", 1'b1, rspFillInhibit)
    refuseEn = 1'b0;
    inhibitEn = 1'b0;
    expNc = 1'b0;
    $display("line read done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Watchdog sized well above the whole test sequence
  initial
  begin
    #(25 * 20000);
    failures++;
    final_report();
  end
  initial
  begin
    rst_b = 1'b0;
    {reqValid, reqInstr, reqCachable, refuseEn, inhibitEn, expNc} = 6'h0;
    prevS = 1'b1;
    reqAddr = 32'h0;
    reqWidth = 2'h0;
    reqUserBits = 2'h2;
    reqClass = 2'h1;
    reqModifier = 3'h5;
    waitClocks = 4'h0;
    nStrobe = 0;
    repeat (10) @(negedge clk_sys);
    rst_b = 1'b1;
    `CHK("reset idle", 2'h3, {reqReady, cycleActive_b})
    test_long();
    test_word_byte();
    test_waits();
    test_prefetch();
    test_line();
    final_report();
  end
endmodule
